// [rtl/amp_control_diag_bytes.v]
// i2c slave holding amplifier control bytes and returning diagnostic bytes
`timescale 1ns/10ps
`default_nettype none
`include "amp_diag_consts.vh"
// Function
// - address bit 0: 0 write, 1 read
// - device returns four diagnostic bytes in order
// - setup D7 selects supply mute threshold
// - setup D6 enables load diagnostics
// - setup D5 starts offset detection
// - setup D4/D3 front/rear gain 30/16 dB
// - setup D2/D1 unmute front/rear pairs
// - setup D0 clip threshold 2%/10%
// - mode D7 selects current threshold pair
// - mode D5 selects fast muting
// - mode D4 releases standby
// - mode D3 selects line-driver diagnostics
// - mode D2 enables current diagnostic
// - mode D1/D0 right/left high efficiency
// - diag1 D7 first thermal warning
// - diag1 D6 diagnostic cycle terminated
// - channel D4 permanent, D3/D1/D0 shorts
// - channel D2 open load or offset
// - channel D5 current open load
// - diag2 D7 offset active, D6 automute
// - diag3 D7/D6 mirror standby, diag enable
// - diag4 D7/D6 warnings two, three
module amp_control_diag_bytes #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input wire core_clk, // system clock
  input wire reset_n, // synchronous reset, active low
  input wire scl_in, // serial clock pin
  input wire sda_in, // serial data pin level
  output reg sda_out, // data drive value, always low
  output reg sda_oe, // high while pulling data low
  input wire [23:0] chan_faults, // 6 fault flags per channel, ch4 in top
  input wire [2:0] thermal_warn, // warnings 1..3
  input wire diag_cycle_done, // diagnostic cycle terminated
  input wire offset_active, // offset detection running
  input wire offset_automute, // offset found, amplifier muted
  output reg mute_thr_high, // supply mute threshold high
  output reg diag_enable, // load diagnostics on
  output reg offset_enable, // offset detection on
  output reg gain_front_16db, // front pair gain 16 dB
  output reg gain_rear_16db, // rear pair gain 16 dB
  output reg unmute_front, // front pair playing
  output reg unmute_rear, // rear pair playing
  output reg clip_10pct, // clip threshold 10 %
  output reg curr_thr_low, // low current threshold pair
  output reg fast_mute, // fast muting time
  output reg amp_run, // standby released
  output reg line_driver_diag, // line-driver diagnostics
  output reg curr_diag_enable, // current diagnostic on
  output reg he_right, // right side high efficiency
  output reg he_left // left side high efficiency
);
  localparam STATE_IDLE = 3'd0;
  localparam STATE_ADDR = 3'd1;
  localparam STATE_WDATA = 3'd2;
  localparam STATE_RDATA = 3'd3;
  localparam STATE_RACK = 3'd4;
  localparam STATE_SKIP = 3'd5;

  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [2:0] byte_cnt_reg;
  reg ack_pend_reg;
  reg [7:0] setup_reg;
  reg [7:0] mode_reg;
  reg [7:0] tx_reg;
  reg [7:0] diag_byte;

  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_cond = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  wire [7:0] byte_in = {shift_reg[6:0], sda_s};

  // per-channel low six bits in common layout
  function [5:0] chan_bits;
    input [23:0] f;
    input [1:0] ch;
    begin
      chan_bits = f[ch*6 +: 6];
    end
  endfunction

  always @* begin
    case (byte_cnt_reg)
      3'd0: diag_byte = {thermal_warn[0], diag_cycle_done, chan_bits(chan_faults, 2'd0)};
      3'd1: diag_byte = {offset_active, offset_automute, chan_bits(chan_faults, 2'd1)};
      3'd2: diag_byte = {mode_reg[`M_RUN], setup_reg[`S_DIAG_EN], chan_bits(chan_faults, 2'd2)};
      default: diag_byte = {thermal_warn[1], thermal_warn[2], chan_bits(chan_faults, 2'd3)};
    endcase
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= STATE_IDLE;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      byte_cnt_reg <= 3'd0;
      ack_pend_reg <= 1'b0;
      setup_reg <= `SETUP_RESET;
      mode_reg <= `MODE_RESET;
      tx_reg <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= STATE_IDLE;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state_reg <= STATE_ADDR;
      bit_cnt_reg <= 4'd0;
      byte_cnt_reg <= 3'd0;
      ack_pend_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state_reg == STATE_RACK) begin
        // host ack low continues, nack ends the read
        if (sda_s)
          state_reg <= STATE_SKIP;
        else
          state_reg <= STATE_RDATA;
      end else if (!ack_pend_reg && (state_reg == STATE_ADDR || state_reg == STATE_WDATA)) begin
        shift_reg <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 4'd1;
      end
    end else if (scl_fall) begin
      sda_out <= 1'b0;
      if (ack_pend_reg) begin
        // ack slot finished
        ack_pend_reg <= 1'b0;
        sda_oe <= 1'b0;
        bit_cnt_reg <= 4'd0;
        if (state_reg == STATE_RDATA) begin
          tx_reg <= {diag_byte[6:0], 1'b0};
          sda_oe <= ~diag_byte[7];
          bit_cnt_reg <= 4'd1;
        end
      end else if (state_reg == STATE_RDATA) begin
        if (bit_cnt_reg == 4'd0) begin
          // host acked: load the next byte of the sequence
          tx_reg <= {diag_byte[6:0], 1'b0};
          sda_oe <= ~diag_byte[7];
          bit_cnt_reg <= 4'd1;
        end else if (bit_cnt_reg == 4'd8) begin
          sda_oe <= 1'b0;
          state_reg <= STATE_RACK;
          bit_cnt_reg <= 4'd0;
          byte_cnt_reg <= (byte_cnt_reg == 3'd3) ? 3'd0 : byte_cnt_reg + 3'd1;
        end else begin
          sda_oe <= ~tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
        end
      end else if (state_reg == STATE_RACK) begin
        sda_oe <= 1'b0;
      end else if (bit_cnt_reg == 4'd8) begin
        if (state_reg == STATE_ADDR) begin
          if (shift_reg[7:1] == DEV_ADDR) begin
            ack_pend_reg <= 1'b1;
            sda_oe <= 1'b1;
            state_reg <= shift_reg[`RW_BIT] ? STATE_RDATA : STATE_WDATA;
          end else begin
            state_reg <= STATE_SKIP;
          end
        end else if (state_reg == STATE_WDATA) begin
          if (byte_cnt_reg == 3'd0) begin
            setup_reg <= shift_reg;
            ack_pend_reg <= 1'b1;
            sda_oe <= 1'b1;
          end else if (byte_cnt_reg == 3'd1) begin
            mode_reg <= shift_reg & ~(8'h01 << `M_FIXED_ZERO);
            ack_pend_reg <= 1'b1;
            sda_oe <= 1'b1;
          end else begin
            state_reg <= STATE_SKIP;
          end
          if (byte_cnt_reg != 3'd7)
            byte_cnt_reg <= byte_cnt_reg + 3'd1;
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      mute_thr_high <= 1'b0;
      diag_enable <= 1'b0;
      offset_enable <= 1'b0;
      gain_front_16db <= 1'b0;
      gain_rear_16db <= 1'b0;
      unmute_front <= 1'b0;
      unmute_rear <= 1'b0;
      clip_10pct <= 1'b0;
      curr_thr_low <= 1'b0;
      fast_mute <= 1'b0;
      amp_run <= 1'b0;
      line_driver_diag <= 1'b0;
      curr_diag_enable <= 1'b0;
      he_right <= 1'b0;
      he_left <= 1'b0;
    end else begin
      mute_thr_high <= setup_reg[`S_MUTE_THR_HIGH];
      diag_enable <= setup_reg[`S_DIAG_EN];
      offset_enable <= setup_reg[`S_OFFSET_EN];
      gain_front_16db <= setup_reg[`S_GAIN_FRONT];
      gain_rear_16db <= setup_reg[`S_GAIN_REAR];
      unmute_front <= setup_reg[`S_UNMUTE_FRONT];
      unmute_rear <= setup_reg[`S_UNMUTE_REAR];
      clip_10pct <= setup_reg[`S_CLIP_10PCT];
      curr_thr_low <= mode_reg[`M_CURR_THR_LOW];
      fast_mute <= mode_reg[`M_FAST_MUTE];
      amp_run <= mode_reg[`M_RUN];
      line_driver_diag <= mode_reg[`M_LINE_DRIVER];
      curr_diag_enable <= mode_reg[`M_CURR_DIAG_EN];
      he_right <= mode_reg[`M_HE_RIGHT];
      he_left <= mode_reg[`M_HE_LEFT];
    end
  end
endmodule // amp_control_diag_bytes
`default_nettype wire

// [rtl/amp_diag_consts.vh]
// constants for the amplifier control and diagnostic byte block
`ifndef AMP_DIAG_CONSTS_VH
`define AMP_DIAG_CONSTS_VH
`define DEV_ADDR_DEFAULT 7'h6C
`define RW_BIT 0
`define WRITE_BYTES 2
`define READ_BYTES 4
`define SETUP_RESET 8'h00
`define MODE_RESET 8'h00
`define S_MUTE_THR_HIGH 7
`define S_DIAG_EN 6
`define S_OFFSET_EN 5
`define S_GAIN_FRONT 4
`define S_GAIN_REAR 3
`define S_UNMUTE_FRONT 2
`define S_UNMUTE_REAR 1
`define S_CLIP_10PCT 0
`define M_CURR_THR_LOW 7
`define M_FIXED_ZERO 6
`define M_FAST_MUTE 5
`define M_RUN 4
`define M_LINE_DRIVER 3
`define M_CURR_DIAG_EN 2
`define M_HE_RIGHT 1
`define M_HE_LEFT 0
`define F_CURR_OPEN 5
`define F_PERMANENT 4
`define F_SHORT_LOAD 3
`define F_OPEN_OFFSET 2
`define F_SHORT_VCC 1
`define F_SHORT_GND 0
`endif

// [testbench/amp_control_diag_bytes_asserts.sv]
// assertions on the control and diagnostic byte block
`timescale 1ns/10ps
`default_nettype none
module amp_control_diag_bytes_asserts (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic scl_in, // serial clock
  input wire logic sda_out, // data value
  input wire logic sda_oe, // data enable
  input wire logic diag_enable, // setup D6
  input wire logic amp_run // mode D4
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence oe_on;
    $rose(sda_oe);
  endsequence
  sequence oe_off;
    $fell(sda_oe);
  endsequence
  a_out_low: assert property (sda_out == 1'b0)
    else $error("data value not low");
  a_oe_late: assert property (oe_on |-> !$past(scl_in, 2) && $past(scl_in, 6))
    else $error("enable rise not after clock fall");
  a_oe_hold: assert property (oe_on |-> sda_oe [*8])
    else $error("enable pulse too short");
  a_oe_free: assert property (oe_off |-> !sda_oe [*8])
    else $error("release too short");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  a_ctrl_scl_low: assert property ($changed(amp_run) || $changed(diag_enable) |-> !scl_in)
    else $error("control moved while clock high");
  a_bytes_apart: assert property ($changed(diag_enable) |-> $stable(amp_run))
    else $error("both control bytes moved together");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !sda_oe && !amp_run && !diag_enable)
    else $error("outputs not quiet in reset");
endmodule // amp_control_diag_bytes_asserts
bind amp_control_diag_bytes amp_control_diag_bytes_asserts amp_control_diag_bytes_asserts_inst (.core_clk(core_clk),
  .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .diag_enable(diag_enable), .amp_run(amp_run));
`default_nettype wire

// [testbench/i2c_host.sv]
// serial bus master model driving clock and data
`timescale 1ns/10ps
`default_nettype none
module i2c_host (
  input wire logic core_clk, // pacing clock
  input wire logic sda, // resolved data line
  output logic scl, // serial clock
  output logic sda_low // pull data low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    q;
    sda_low = !b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
  endtask
  // stop when set, start otherwise
  task automatic cond(input logic stop_c);
    q;
    sda_low = stop_c;
    q;
    scl = 1'b1;
    q;
    sda_low = !stop_c;
    q;
    scl = stop_c;
  endtask
  task automatic xfer(input logic [7:0] w, input logic ack_in, output logic [7:0] r, output logic ack_out);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], b);
      r = {r[6:0], b};
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule // i2c_host
`default_nettype wire

// [testbench/test_amp_control_diag_bytes.sv]
// self-checking bench for the control and diagnostic byte block
`timescale 1ns/10ps
`default_nettype none
`include "amp_diag_consts.vh"
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin error_cnt++; $display("BAD %0t %h %h", $time, x, y); end end
module test_amp_control_diag_bytes;
  logic core_clk, reset_n, scl, sda_low, done, off_act, off_mute, a;
  logic [23:0] faults;
  logic [2:0] warn;
  logic [7:0] r, cur_s, cur_m;
  wire logic sda_oe, sda_out;
  wire logic [7:0] setup_q;
  wire logic [6:0] mode_q;
  wire logic sda = !(sda_oe || sda_low);
  int error_cnt = 0;
  int checks = 0;
  amp_control_diag_bytes amp_control_diag_bytes_inst (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chan_faults(faults), .thermal_warn(warn),
    .diag_cycle_done(done), .offset_active(off_act), .offset_automute(off_mute), .mute_thr_high(setup_q[7]),
    .diag_enable(setup_q[6]), .offset_enable(setup_q[5]), .gain_front_16db(setup_q[4]), .gain_rear_16db(setup_q[3]),
    .unmute_front(setup_q[2]), .unmute_rear(setup_q[1]), .clip_10pct(setup_q[0]), .curr_thr_low(mode_q[6]),
    .fast_mute(mode_q[5]), .amp_run(mode_q[4]), .line_driver_diag(mode_q[3]), .curr_diag_enable(mode_q[2]),
    .he_right(mode_q[1]), .he_left(mode_q[0]));
  i2c_host i2c_host_inst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic addr(input logic [6:0] ad, input logic rd_w, input logic exp_nack);
    i2c_host_inst.cond(1'b0);
    i2c_host_inst.xfer({ad, rd_w}, 1'b1, r, a);
    `CHK(a, exp_nack)
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] m, input logic extra);
    addr(`DEV_ADDR_DEFAULT, 1'b0, 1'b0);
    i2c_host_inst.xfer(s, 1'b1, r, a);
    `CHK(a, 1'b0)
    i2c_host_inst.xfer(m, 1'b1, r, a);
    `CHK(a, 1'b0)
    if (extra) begin
      i2c_host_inst.xfer(~s, 1'b1, r, a);
      `CHK(a, 1'b1)
    end
    i2c_host_inst.cond(1'b1);
    cur_s = s;
    cur_m = m;
    `CHK(setup_q, s)
    `CHK(mode_q, {m[7], m[5:0]})
  endtask
  task automatic rd;
    logic [7:0] e [4];
    e[0] = {warn[0], done, faults[5:0]};
    e[1] = {off_act, off_mute, faults[11:6]};
    e[2] = {cur_m[4], cur_s[6], faults[17:12]};
    e[3] = {warn[1], warn[2], faults[23:18]};
    addr(`DEV_ADDR_DEFAULT, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      i2c_host_inst.xfer(8'hFF, i == 3, r, a);
      `CHK(r, e[i])
    end
    i2c_host_inst.cond(1'b1);
  endtask
  initial begin
    reset_n = 1'b0;
    faults = 24'h000000;
    warn = 3'h0;
    done = 1'b0;
    off_act = 1'b0;
    off_mute = 1'b0;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(setup_q, `SETUP_RESET)
    `CHK(mode_q, 7'h00)
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      faults = i ? 24'hA5C3F0 : 24'h5A3C0F;
      warn = i ? 3'h5 : 3'h2;
      done = i;
      off_act = !i;
      off_mute = i;
      wr(i ? 8'h5A : 8'hA5, i ? 8'hAA : 8'h15, 1'b0);
      rd;
    end
    $display("write read test done");
    wr(8'h3C, 8'h2D, 1'b1);
    addr(`DEV_ADDR_DEFAULT ^ 7'h01, 1'b0, 1'b1);
    i2c_host_inst.cond(1'b1);
    `CHK(setup_q, 8'h3C)
    $display("refusal test done");
    end_of_test;
  end
endmodule // test_amp_control_diag_bytes
`default_nettype wire
